// ==== logic/cdp_pkg.sv ====
package cdp_pkg;
  // ****************************************************************
  // Register map (byte addresses on the bus).
  // ****************************************************************
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_EVENT  = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_ADDR   = 8'h0c;
  localparam logic [7:0] OFS_FLUSH  = 8'h10;
  localparam int         REG_W      = 16;
  localparam int         ADDR_W     = 22;
  localparam int         INDEX_W    = 12;
  localparam int         LABEL_W    = 9;
  localparam int         TAG_W      = 11;
  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int ST_ABORT   = 15;
  localparam int ST_HIGH    = 7;
  localparam int ST_LOW     = 6;
  localparam int ST_TAG     = 5;
  localparam int EV_ENABLE  = 6;
  localparam int CC_TAGBAD  = 10;
  localparam int CC_FLUSH   = 8;
  localparam int CC_ABORT   = 7;
  localparam int CC_DATABAD = 6;
  localparam int CC_NOINT   = 0;
  localparam int IDX_LSB    = 1;
  localparam int LABEL_LSB  = 13;
  localparam int TAG_VALID  = 9;
  localparam int TAG_PAR    = 10;
  localparam logic [REG_W-1:0] STATUS_MASK = 16'h80e0;
  localparam logic [REG_W-1:0] EVENT_MASK  = 16'h0040;
  localparam logic [REG_W-1:0] CTRL_MASK   = 16'h05c3;
  // ****************************************************************
  // Codes.
  // ****************************************************************
  localparam logic [1:0] SEL_NONE  = 2'h0;
  localparam logic [1:0] SEL_ADDR  = 2'h1;
  localparam logic [1:0] SEL_REG   = 2'h2;
  localparam logic [1:0] SEL_FLUSH = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ==== logic/cdp_byte_parity.sv ====
module cdp_byte_parity #(
  parameter int   WIDTH = 8,
  parameter logic ODD   = 1'b0
) (
  input  wire logic [WIDTH-1:0] data,
  input  wire logic             select,
  input  wire logic             write_en,
  input  wire logic             update,
  input  wire logic             wrong,
  input  wire logic             stored_par,
  output logic                  par_write,
  output logic                  par_error
);
  // ****************************************************************
  // Generate on update, check on a selected read.
  // ****************************************************************
  logic gen;
  assign gen       = (^data) ^ ODD;
  assign par_write = update ? (gen ^ wrong) : gen; // R20 R22
  assign par_error = select & ~write_en & ~update & (stored_par != gen); // R21 R22
endmodule

// ==== logic/cdp_flush_counter.sv ====
module cdp_flush_counter #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             start,
  input  wire logic             step,
  output logic [WIDTH-1:0]      count,
  output logic                  active,
  output logic                  done
);
  // ****************************************************************
  // Counter walks every index once, then overflows.
  // ****************************************************************
  logic [WIDTH:0] next_count;
  assign next_count = {1'b0, count} + {{WIDTH{1'b0}}, 1'b1};
  always_ff @(posedge clk) begin
    if (reset) begin
      count  <= '0;
      active <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count  <= '0; // R9
        active <= 1'b1; // R9
      end else if (active && step) begin
        count <= next_count[WIDTH-1:0]; // R10
        if (next_count[WIDTH]) begin
          active <= 1'b0; // R11
          done   <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== logic/cdp_top.sv ====
// What this block does
// R1: Error status is read-only, bits 15,7,6,5; any write clears it.
// R2: Bit 15 sets on parity or memory error in demand read with abort on.
// R3: Abort mode on: bits 7,6,5 flag high, low and tag errors apart.
// R4: Abort mode off: any cache parity error sets bits 7,6,5 together.
// R5: Status drives data out on select code 10 unless event address chosen.
// R6: Event-enable register is read/write; its bit 6 drives event enable.
// R7: Event flop captures received event; gated by enable gives interrupt.
// R8: Clear-event or module init resets the event flop.
// R9: Flush starts at power-up and on control bit 8: zero counter, flag.
// R10: Flush counter drives cache index; long cycle advances it.
// R11: Twelve-bit counter; overflow ends flush and drops flush-active.
// R12: Address latched early, driven back on select; bits 12:1 index cache.
// R13: On update, latched bits 21:13 go onto the tag bus as label.
// R14: Wrong-data-parity output follows control bit 6.
// R15: Predicted tag parity is parity of address bits 21:13.
// R16: Processor maps abort and parity outputs to vectors 114 or 4.
// R17: General-purpose write strobe follows the matching transaction code.
// R18: I/O page select on I/O bank code, bypass or forced miss.
// R19: Special-address select when maintenance or event register addressed.
// R20: High byte odd parity, low byte even, tag parity even.
// R21: Byte parity read on its select; written with select and write enable.
// R22: Parity generated on update, inverted when wrong; good goes low on match.
// R23: Select code picks none, address, status or event, or flush counter.
// R24: Update and check pick predict, check or generate of tag parity.
// R25: Each flush cycle writes its tag entry with valid cleared.
module cdp_top #(
  parameter logic [21:0] MAINT_ADDR   = 22'h3fffe8,
  parameter logic [21:0] EVENT_ADDR   = 22'h3fff66,
  parameter logic [3:0]  GP_WRITE_TT  = 4'h7,
  parameter logic [1:0]  IO_BANK_CODE = 2'h3
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [3:0]  transaction_type_code,
  input  wire logic [1:0]  bank_select_code,
  input  wire logic        addr_strobe,
  input  wire logic        bypass_or_miss,
  input  wire logic [21:0] bus_addr_in,
  input  wire logic [1:0]  out_select,
  input  wire logic        demand_read,
  input  wire logic        mem_error,
  input  wire logic        update,
  input  wire logic        check,
  input  wire logic        long_cycle,
  input  wire logic [15:0] cache_data_in,
  input  wire logic        high_byte_select,
  input  wire logic        low_byte_select,
  input  wire logic        ram_write_enable,
  input  wire logic        high_parity_read,
  input  wire logic        low_parity_read,
  input  wire logic        tag_parity_read,
  input  wire logic        bus_event_in,
  input  wire logic        clear_event,
  input  wire logic        module_init,
  output logic [21:0]      dal_out,
  output logic             dal_out_en,
  output logic [11:0]      cache_index,
  output logic [10:0]      tag_bus_out,
  output logic             tag_bus_en,
  output logic             predicted_tag_parity,
  output logic             high_parity_write,
  output logic             low_parity_write,
  output logic             parity_good_n,
  output logic             force_bad_parity,
  output logic             parity_error_out,
  output logic             abort_out,
  output logic             flush_active,
  output logic             event_enable_out,
  output logic             event_interrupt_req,
  output logic             gp_write_strobe,
  output logic             io_page_select,
  output logic             special_address_select
);
  // ****************************************************************
  // State.
  // ****************************************************************
  logic [cdp_pkg::REG_W-1:0]   memory_error_status;
  logic [cdp_pkg::REG_W-1:0]   event_enable_control;
  logic [cdp_pkg::REG_W-1:0]   cache_control_reg;
  logic [cdp_pkg::ADDR_W-1:0]  addr_reg;
  logic [cdp_pkg::INDEX_W-1:0] flush_count;
  logic                        flush_run;
  logic                        flush_done;
  logic                        flush_start;
  logic                        powered_up;
  logic                        received_event;
  logic                        event_seen;
  logic                        io_bank_latched;
  logic                        dph_valid;
  logic                        dph_write;
  logic [7:0]                  dph_addr;
  logic [1:0]                  byte_par_write;
  logic [1:0]                  byte_par_error;
  logic [1:0]                  byte_select;
  logic [1:0]                  byte_stored;
  logic [cdp_pkg::LABEL_W-1:0] label;
  logic                        label_par;
  logic                        tag_error;
  logic                        any_error;
  logic                        event_addr_hit;
  logic                        wr_status;
  logic                        wr_event;
  logic                        wr_ctrl;
  logic [cdp_pkg::REG_W-1:0]   status_set;
  logic [cdp_pkg::REG_W-1:0]   wdata16;

  // ****************************************************************
  // Address match, used by several outputs.
  // ****************************************************************
  function automatic logic addr_is(input logic [21:0] a,
                                   input logic [21:0] ref_addr);
    addr_is = (a == ref_addr);
  endfunction

  assign event_addr_hit = addr_is(addr_reg, EVENT_ADDR);
  assign label     = addr_reg[cdp_pkg::LABEL_LSB +: cdp_pkg::LABEL_W];
  assign label_par = ^label; // R15 R20

  // ****************************************************************
  // Bus slave: zero wait states, writes land in the data phase.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr  <= 8'h00;
    end else if (hready) begin
      dph_valid <= hsel && (htrans == cdp_pkg::HTRANS_NONSEQ);
      dph_write <= hwrite;
      dph_addr  <= haddr[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && !hwrite &&
                 htrans == cdp_pkg::HTRANS_NONSEQ) begin
      case (haddr[7:0])
        cdp_pkg::OFS_STATUS: hrdata <= {16'h0000, memory_error_status};
        cdp_pkg::OFS_EVENT:  hrdata <= {16'h0000, event_enable_control};
        cdp_pkg::OFS_CTRL:   hrdata <= {16'h0000, cache_control_reg};
        cdp_pkg::OFS_ADDR:   hrdata <= {10'h000, addr_reg};
        cdp_pkg::OFS_FLUSH:  hrdata <= {15'h0000, flush_run,
                                        4'h0, flush_count};
        default:             hrdata <= 32'h00000000;
      endcase
    end
  end

  assign wdata16   = hwdata[cdp_pkg::REG_W-1:0];
  assign wr_status = dph_valid && dph_write &&
                     dph_addr == cdp_pkg::OFS_STATUS;
  assign wr_event  = dph_valid && dph_write &&
                     dph_addr == cdp_pkg::OFS_EVENT;
  assign wr_ctrl   = dph_valid && dph_write &&
                     dph_addr == cdp_pkg::OFS_CTRL;

  // ****************************************************************
  // Parity generation and check for both data bytes.
  // ****************************************************************
  assign byte_select = {high_byte_select, low_byte_select};
  assign byte_stored = {high_parity_read, low_parity_read};

  for (genvar b = 0; b < 2; b++) begin : g_byte
    cdp_byte_parity #(
      .WIDTH (8),
      .ODD   (b == 1)
    ) u_par (
      .data       (cache_data_in[8*b +: 8]),
      .select     (byte_select[b]),
      .write_en   (ram_write_enable),
      .update     (update),
      .wrong      (cache_control_reg[cdp_pkg::CC_DATABAD]),
      .stored_par (byte_stored[b]),
      .par_write  (byte_par_write[b]),
      .par_error  (byte_par_error[b])
    );
  end

  assign tag_error = check && !update &&
                     (tag_parity_read != label_par); // R24
  assign any_error = |byte_par_error || tag_error;

  always_ff @(posedge clk) begin
    if (reset) begin
      high_parity_write <= 1'b0;
      low_parity_write  <= 1'b0;
      parity_good_n     <= 1'b0;
    end else begin
      high_parity_write <= byte_par_write[1]; // R20
      low_parity_write  <= byte_par_write[0]; // R20
      parity_good_n     <= |byte_par_error; // R22
    end
  end

  // ****************************************************************
  // Memory error status: hardware set wins over the write clear.
  // ****************************************************************
  always_comb begin
    status_set = '0;
    if (cache_control_reg[cdp_pkg::CC_ABORT]) begin
      status_set[cdp_pkg::ST_HIGH] = byte_par_error[1]; // R3
      status_set[cdp_pkg::ST_LOW]  = byte_par_error[0]; // R3
      status_set[cdp_pkg::ST_TAG]  = tag_error; // R3
      status_set[cdp_pkg::ST_ABORT] =
        demand_read && (any_error || mem_error); // R2
    end else if (any_error) begin
      status_set[cdp_pkg::ST_HIGH] = 1'b1; // R4
      status_set[cdp_pkg::ST_LOW]  = 1'b1; // R4
      status_set[cdp_pkg::ST_TAG]  = 1'b1; // R4
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      memory_error_status <= '0;
    end else begin
      memory_error_status <= ((wr_status ? '0 : memory_error_status) |
                              status_set) & cdp_pkg::STATUS_MASK; // R1
    end
  end

  // ****************************************************************
  // Abort and parity outputs.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      abort_out        <= 1'b0;
      parity_error_out <= 1'b0;
    end else begin
      abort_out <= cache_control_reg[cdp_pkg::CC_ABORT] && demand_read &&
                   (any_error || mem_error);
      parity_error_out <= (any_error || mem_error) &&
                          (cache_control_reg[cdp_pkg::CC_ABORT] ||
                           !cache_control_reg[cdp_pkg::CC_NOINT]);
    end
  end

  // ****************************************************************
  // Event enable and event interrupt.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      event_enable_control <= '0;
      event_enable_out     <= 1'b0;
    end else begin
      if (wr_event) begin
        event_enable_control <= wdata16 & cdp_pkg::EVENT_MASK; // R6
      end
      event_enable_out <= event_enable_control[cdp_pkg::EV_ENABLE]; // R6
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      received_event      <= 1'b0;
      event_seen          <= 1'b0;
      event_interrupt_req <= 1'b0;
    end else begin
      received_event <= bus_event_in;
      if (bus_event_in && !received_event) begin
        event_seen <= 1'b1; // R7
      end else if (clear_event || module_init) begin
        event_seen <= 1'b0; // R8
      end
      event_interrupt_req <= event_seen && event_enable_out; // R7
    end
  end

  // ****************************************************************
  // Cache control shadow and flush.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      cache_control_reg <= '0;
    end else if (wr_ctrl) begin
      cache_control_reg <= wdata16 & cdp_pkg::CTRL_MASK;
    end else if (flush_done) begin
      cache_control_reg[cdp_pkg::CC_FLUSH] <= 1'b0; // R11
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      powered_up <= 1'b0;
    end else begin
      powered_up <= 1'b1;
    end
  end

  assign flush_start = !powered_up ||
                       (wr_ctrl && wdata16[cdp_pkg::CC_FLUSH]); // R9

  cdp_flush_counter #(
    .WIDTH (cdp_pkg::INDEX_W)
  ) u_flush (
    .clk    (clk),
    .reset  (reset),
    .start  (flush_start),
    .step   (long_cycle),
    .count  (flush_count),
    .active (flush_run),
    .done   (flush_done)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      flush_active <= 1'b0;
      cache_index  <= '0;
    end else begin
      flush_active <= flush_run && !flush_done; // R9 R11
      cache_index  <= flush_run ? flush_count :
        addr_reg[cdp_pkg::IDX_LSB +: cdp_pkg::INDEX_W]; // R10 R12
    end
  end

  // ****************************************************************
  // Address register and tag bus.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_reg        <= '0;
      io_bank_latched <= 1'b0;
    end else if (addr_strobe) begin
      addr_reg        <= bus_addr_in; // R12
      io_bank_latched <= (bank_select_code == IO_BANK_CODE);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tag_bus_out          <= '0;
      tag_bus_en           <= 1'b0;
      predicted_tag_parity <= 1'b0;
      force_bad_parity     <= 1'b0;
    end else begin
      tag_bus_en <= flush_run || (update && !check);
      if (flush_run) begin
        tag_bus_out <= '0; // R25
      end else begin
        tag_bus_out[cdp_pkg::LABEL_W-1:0] <= label; // R13
        tag_bus_out[cdp_pkg::TAG_VALID]   <= 1'b1;
        tag_bus_out[cdp_pkg::TAG_PAR]     <= label_par ^
          cache_control_reg[cdp_pkg::CC_TAGBAD]; // R24
      end
      predicted_tag_parity <= label_par; // R15
      force_bad_parity <= cache_control_reg[cdp_pkg::CC_DATABAD]; // R14
    end
  end

  // ****************************************************************
  // Data output select and transaction decodes.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      dal_out    <= '0;
      dal_out_en <= 1'b0;
    end else begin
      dal_out_en <= (out_select != cdp_pkg::SEL_NONE); // R23
      case (out_select)
        cdp_pkg::SEL_ADDR:  dal_out <= addr_reg; // R12 R23
        cdp_pkg::SEL_REG:   dal_out <= event_addr_hit ?
          {6'h00, event_enable_control} :
          {6'h00, memory_error_status}; // R5
        cdp_pkg::SEL_FLUSH: dal_out <= {10'h000, flush_count}; // R23
        default:            dal_out <= '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      gp_write_strobe        <= 1'b0;
      io_page_select         <= 1'b0;
      special_address_select <= 1'b0;
    end else begin
      gp_write_strobe <= (transaction_type_code == GP_WRITE_TT); // R17
      io_page_select  <= (addr_strobe ?
        (bank_select_code == IO_BANK_CODE) : io_bank_latched) ||
        bypass_or_miss; // R18
      special_address_select <= addr_is(addr_reg, MAINT_ADDR) ||
                                event_addr_hit; // R19
    end
  end
endmodule

// ==== tb/cdp_chk.sv ====
module cdp_chk #(
  parameter logic [3:0] GP_WRITE_TT  = 4'h7,
  parameter logic [1:0] IO_BANK_CODE = 2'h3
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  transaction_type_code,
  input wire logic [1:0]  bank_select_code,
  input wire logic        addr_strobe,
  input wire logic        bypass_or_miss,
  input wire logic [21:0] bus_addr_in,
  input wire logic        update,
  input wire logic        long_cycle,
  input wire logic [15:0] cache_data_in,
  input wire logic        high_byte_select,
  input wire logic        low_byte_select,
  input wire logic        ram_write_enable,
  input wire logic [11:0] cache_index,
  input wire logic [10:0] tag_bus_out,
  input wire logic        predicted_tag_parity,
  input wire logic        high_parity_write,
  input wire logic        low_parity_write,
  input wire logic        force_bad_parity,
  input wire logic        flush_active,
  input wire logic        gp_write_strobe,
  input wire logic        io_page_select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  pred_par_a: assert property (
    addr_strobe ##1 $stable(bus_addr_in) |=> predicted_tag_parity ==
    ^$past(bus_addr_in[21:13])) else $error("Predicted parity wrong.");
  gp_strobe_a: assert property (
    addr_strobe ##1 $stable(transaction_type_code) |=> gp_write_strobe ==
    ($past(transaction_type_code) == GP_WRITE_TT)) else $error("Gp strobe.");
  io_page_a: assert property (
    addr_strobe ##1 $stable({bank_select_code, bypass_or_miss}) |=>
    io_page_select == ($past(bank_select_code) == IO_BANK_CODE ||
    $past(bypass_or_miss))) else $error("Io page select wrong.");
  tag_label_a: assert property (
    addr_strobe ##1 $stable(bus_addr_in) && update && !flush_active |=>
    tag_bus_out[8:0] == $past(bus_addr_in[21:13])) else $error("Label.");
  high_par_a: assert property (
    update && high_byte_select && ram_write_enable && !force_bad_parity
    |=> high_parity_write == ~^$past(cache_data_in[15:8]))
    else $error("High parity wrong.");
  low_par_a: assert property (
    update && low_byte_select && ram_write_enable && !force_bad_parity
    |=> low_parity_write == ^$past(cache_data_in[7:0]))
    else $error("Low parity wrong.");
  flush_step_a: assert property (
    (flush_active && long_cycle) [*3] |=> !flush_active ||
    cache_index == $past(cache_index) + 12'h1) else $error("Flush step.");
  flush_tag_a: assert property (
    flush_active [*3] |-> tag_bus_out == 11'h000) else $error("Flush tag.");
endmodule

bind cdp_top cdp_chk #(
  .GP_WRITE_TT (GP_WRITE_TT),
  .IO_BANK_CODE(IO_BANK_CODE)
) u_chk (.*);

// ==== tb/cdp_ram_model.sv ====
module cdp_ram_model #(
  parameter bit SLOW = 1'b0
) (
  input  wire logic clk,
  input  wire logic flush_active,
  input  wire logic high_byte_select,
  input  wire logic low_byte_select,
  input  wire logic ram_write_enable,
  input  wire logic high_parity_write,
  input  wire logic low_parity_write,
  output logic      long_cycle,
  output logic      high_parity_read,
  output logic      low_parity_read
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       tick = 1'b0;
  logic [1:0] wr_d = 2'h0;
  logic [1:0] par  = 2'h0;
  initial long_cycle = 1'b0;
  always @(posedge clk) begin
    tick <= ~tick;
    long_cycle <= flush_active && (!SLOW || tick);
    wr_d <= {high_byte_select, low_byte_select} & {2{ram_write_enable}};
    if (wr_d[1]) par[1] <= high_parity_write;
    if (wr_d[0]) par[0] <= low_parity_write;
  end
  // An unselected byte shows the inverse of its stored bit.
  assign high_parity_read = high_byte_select ? par[1] : ~par[1];
  assign low_parity_read = low_byte_select ? par[0] : ~par[0];
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [21:0] MNT_ADDR = 22'h3fffe8;
  localparam logic [21:0] EV_ADDR  = 22'h3fff66;
  logic        clk, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, bank_select_code, out_select;
  logic [2:0]  hsize;
  logic [3:0]  transaction_type_code;
  logic        addr_strobe, bypass_or_miss, demand_read, mem_error;
  logic        update, check, long_cycle, high_byte_select, low_byte_select;
  logic        ram_write_enable, high_parity_read, low_parity_read;
  logic        tag_parity_read, bus_event_in, clear_event, module_init;
  logic [21:0] bus_addr_in, dal_out;
  logic [15:0] cache_data_in;
  logic [11:0] cache_index;
  logic [10:0] tag_bus_out;
  logic        dal_out_en, tag_bus_en, predicted_tag_parity, abort_out;
  logic        high_parity_write, low_parity_write, parity_good_n;
  logic        force_bad_parity, parity_error_out, flush_active;
  logic        event_enable_out, event_interrupt_req, gp_write_strobe;
  logic        io_page_select, special_address_select;
  int          n_errors, n_tests;
  assign hready = hreadyout;
  cdp_top #(.MAINT_ADDR(MNT_ADDR), .EVENT_ADDR(EV_ADDR)) u_dut (.*);
  cdp_ram_model #(.SLOW(1'b0)) u_ram (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    htrans <= cdp_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    chk(hresp, 1'b0);
  endtask
  task automatic t_flush();
    int n;
    n = 0;
    while (flush_active !== 1'b1 && n < 20) @(posedge clk) n++;
    chk({flush_active, tag_bus_en}, 2'h3);
    n = 0;
    while (flush_active === 1'b1 && n < 5000) @(posedge clk) n++;
    chk(n >= 4096 && n <= 4100, 1);
  endtask
  task automatic cw(input logic [15:0] d);
    cache_data_in <= d;
    {high_byte_select, low_byte_select, ram_write_enable, update} <= 4'hf;
    repeat (3) @(posedge clk);
    {high_byte_select, low_byte_select, ram_write_enable, update} <= 4'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic cr(input logic [1:0] sel, input logic bad, logic [1:0] ap);
    {high_byte_select, low_byte_select} <= sel;
    repeat (3) @(posedge clk);
    chk({parity_good_n, abort_out, parity_error_out}, {bad, ap});
    {high_byte_select, low_byte_select} <= 2'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_addr(input logic [21:0] a, input logic [3:0] tt,
                        input logic [1:0] bs, input logic bm,
                        input logic [2:0] exp);
    bus_addr_in <= a;
    transaction_type_code <= tt;
    bank_select_code <= bs;
    bypass_or_miss <= bm;
    {addr_strobe, update} <= 2'h3;
    repeat (3) @(posedge clk);
    {addr_strobe, update} <= 2'h0;
    out_select <= cdp_pkg::SEL_ADDR;
    repeat (3) @(posedge clk);
    chk({dal_out_en, dal_out}, {1'b1, a});
    chk(cache_index, a[12:1]);
    chk({special_address_select, gp_write_strobe, io_page_select}, exp);
    out_select <= cdp_pkg::SEL_NONE;
  endtask
  task automatic t_event(input logic init);
    bus_event_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk(event_interrupt_req, 1);
    bus_event_in <= 1'b0;
    clear_event <= !init;
    module_init <= init;
    repeat (3) @(posedge clk);
    chk(event_interrupt_req, 0);
    {clear_event, module_init} <= 2'h0;
  endtask
  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d.", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    print_verdict();
  end
  initial begin
    n_errors = 0;
    n_tests = 0;
    {hwrite, htrans, haddr, hwdata, bank_select_code, out_select} = '0;
    {transaction_type_code, addr_strobe, bypass_or_miss, demand_read} = '0;
    {mem_error, update, check, bus_addr_in, cache_data_in} = '0;
    {high_byte_select, low_byte_select, ram_write_enable} = '0;
    {tag_parity_read, bus_event_in, clear_event, module_init} = '0;
    {hsel, hsize, reset} = 5'h15;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_flush();
    ahb(1'b0, cdp_pkg::OFS_STATUS, 32'h0, q);
    chk(q, 32'h0);
    ahb(1'b1, cdp_pkg::OFS_EVENT, 32'hffff, q);
    ahb(1'b0, cdp_pkg::OFS_EVENT, 32'h0, q);
    chk(q, 32'h40);
    chk(event_enable_out, 1);
    ahb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    cw(16'h12f3);
    cr(2'h3, 1'b0, 2'h0);
    ahb(1'b1, cdp_pkg::OFS_CTRL, 32'h40, q);
    repeat (2) @(posedge clk);
    chk(force_bad_parity, 1);
    cw(16'h12f3);
    ahb(1'b1, cdp_pkg::OFS_CTRL, 32'h0, q);
    cr(2'h2, 1'b1, 2'h1);
    ahb(1'b0, cdp_pkg::OFS_STATUS, 32'h0, q);
    chk(q, 32'he0);
    ahb(1'b1, cdp_pkg::OFS_STATUS, 32'h0, q);
    ahb(1'b0, cdp_pkg::OFS_STATUS, 32'h0, q);
    chk(q, 32'h0);
    ahb(1'b1, cdp_pkg::OFS_CTRL, 32'h80, q);
    demand_read <= 1'b1;
    cr(2'h2, 1'b1, 2'h3);
    {demand_read, check, tag_parity_read} <= 3'h3;
    out_select <= cdp_pkg::SEL_REG;
    ahb(1'b0, cdp_pkg::OFS_STATUS, 32'h0, q);
    chk(q, 32'h80a0);
    chk({dal_out_en, dal_out[15:0]}, 32'h180a0);
    {out_select, check} <= 3'h0;
    t_addr(MNT_ADDR, 4'h7, 2'h3, 1'b0, 3'h7);
    t_addr(EV_ADDR, 4'h0, 2'h0, 1'b1, 3'h5);
    t_addr(22'h001ffe, 4'h0, 2'h0, 1'b0, 3'h0);
    ahb(1'b1, cdp_pkg::OFS_CTRL, 32'h100, q);
    t_flush();
    t_event(1'b0);
    t_event(1'b1);
    print_verdict();
  end
endmodule
